// ### logic/ipw_ctrl.sv
/*
  Interrupt software-priority tracking, vector selection and wait/halt
  control for an 8-bit core. Assumes the core sequencer issues one
  instruction command per cycle and acknowledges an entry with take_in.
*/
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Priority bits held at condition code bits 5,3
// - Level encoding 10,01,00,11 for levels 0-3
// - Condition code resets to 111x1010
// - Entry loads priority from source's register
// - Instructions may rewrite the priority bits
// - Top-level irq, trap, reset pass level 3
// - Priority registers reset FF, SPR3[7:4] read-only
// - Instruction priority persists until next change
// - Source 0 vector FFFA, cannot exit halt
// - Ports C/A wake sources exit halt
// - Card presence source exits USB suspend
// - Reset starts in run mode
// - Wait stops CPU, peripherals keep running
// - Mask bit held 0 during wait
// - Wait ends on interrupt, jump vector
// - Wait alters nothing but mask bit; code sets both priority bits 5,3 to 10 (level 0)
// - Highest software then hardware priority wins
// - Unserved requests stay latched pending
// - Maskable taken when enabled and above level
// - Non-maskable entry sets level 3
module ipw_ctrl import ipw_pkg::*; #(
  parameter int SRC_COUNT = NUM_SRC
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  output logic wb_err_out,
  input wire ipw_cmd_t cmd_in,
  input wire logic [SRC_COUNT-1:0] irq_req_in,
  input wire logic take_in,
  output logic entry_valid_out,
  output ipw_entry_t entry_out,
  output logic [7:0] condition_code_register_out,
  output logic cpu_stop_out,
  output logic periph_clk_en_out,
  output logic suspend_wake_out
);
  // The source map and vector table are fixed at nine entries
  if (SRC_COUNT != NUM_SRC) begin : g_bad_count
    $error("SRC_COUNT must equal 9");
  end

  logic [7:0] cond;
  logic trap_pend;
  logic [7:0] spr [4];
  logic [8:0] enable;
  logic [8:0] pending;
  logic [8:0] irq_q1, irq_q2, irq_q3;
  ipw_state_t state, next_state;
  ipw_entry_t next_entry;
  logic entry_valid;
  logic [7:0] next_cond;

  // Two-stage synchroniser then edge detect on the third stage
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_q1 <= 9'h000;
      irq_q2 <= 9'h000;
      irq_q3 <= 9'h000;
    end else begin
      irq_q1 <= irq_req_in;
      irq_q2 <= irq_q1;
      irq_q3 <= irq_q2;
    end
  end
  wire [8:0] irq_rise = irq_q2 & ~irq_q3;

  wire [1:0] cur_lvl = {cond[COND_PRIO_HI_POS], cond[COND_PRIO_LO_POS]};
  // Map the encoding to a rank 0..3 so comparisons are plain
  function automatic logic [1:0] rank(input logic [1:0] p);
    case (p)
      LVL0: rank = 2'd0;
      LVL1: rank = 2'd1;
      LVL2: rank = 2'd2;
      default: rank = 2'd3;
    endcase
  endfunction

  logic [1:0] src_prio [9];
  logic [8:0] eligible;
  genvar g;
  generate
    for (g = 0; g < 9; g++) begin : g_src
      assign src_prio[g] = spr[g / 4][(g % 4) * 2 +: 2];
      // enabled and strictly above the current level; source 0 is the NMI
      assign eligible[g] = pending[g] && ((g == FLASH_SRC) ||
        (enable[g] && rank(src_prio[g]) > rank(cur_lvl)));
    end
  endgenerate

  // Pick highest rank, lowest index on ties
  logic [3:0] win;
  logic [1:0] win_rank;
  logic win_any;
  logic [8:0] halt_ok;
  always_comb begin
    win = 4'h0;
    win_rank = 2'd0;
    win_any = 1'b0;
    halt_ok = (state == ST_HALT) ? HALT_EXIT_MASK : 9'h1FF;
    for (int i = 8; i >= 0; i--) begin
      if (eligible[i] && halt_ok[i]) begin
        if (!win_any || (i == FLASH_SRC) || rank(src_prio[i]) >= win_rank) begin
          win = 4'(i);
          win_rank = (i == FLASH_SRC) ? 2'd3 : rank(src_prio[i]);
          win_any = 1'b1;
        end
      end
    end
  end

  wire nmi_win = win_any && (win == 4'(FLASH_SRC));
  always_comb begin
    next_entry.src = win;
    next_entry.nmi = nmi_win;
    next_entry.vector = VEC_SRC0 - {11'h000, win, 1'b0};
    if (cmd_in.op == OP_TRAP || trap_pend) begin
      next_entry.vector = VEC_TRAP;
      next_entry.nmi = 1'b1;
    end
  end
  // The trap is a one-cycle command, so it is latched until the core takes it
  wire entry_req = win_any || trap_pend || (cmd_in.op == OP_TRAP);
  wire taking = entry_valid && take_in;

  // Condition code update
  always_comb begin
    next_cond = cond;
    case (cmd_in.op)
      OP_UNMASK, OP_MASK, OP_HALT, OP_RETURN_FROM_IRQ_INSTR, OP_POPFLAGS, OP_WRCOND: next_cond = cmd_in.data;
      OP_WAIT: begin
        next_cond[COND_PRIO_HI_POS] = WAIT_PRIO[1];
        next_cond[COND_PRIO_LO_POS] = WAIT_PRIO[0];
      end
      OP_TRAP: begin
        next_cond[COND_PRIO_HI_POS] = 1'b1;
        next_cond[COND_PRIO_LO_POS] = 1'b1;
      end
      default: next_cond = cond;
    endcase
    if (taking) begin
      if (entry_out.nmi) begin
        next_cond[COND_PRIO_HI_POS] = LVL3[1];
        next_cond[COND_PRIO_LO_POS] = LVL3[0];
      end else begin
        next_cond[COND_PRIO_HI_POS] = src_prio[entry_out.src][1];
        next_cond[COND_PRIO_LO_POS] = src_prio[entry_out.src][0];
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (cmd_in.op == OP_WAIT) next_state = ST_WAIT;
        else if (cmd_in.op == OP_HALT) next_state = ST_HALT;
      end
      ST_WAIT, ST_HALT: if (taking) next_state = ST_RUN;
      default: next_state = ST_RUN;
    endcase
  end

  // Bus decode
  wire bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out;
  wire [7:0] wdat = wb_dat_in[7:0];
  wire wlane = wb_sel_in[0];
  wire adr_cond = wb_adr_in == OFS_COND;
  wire [3:0] adr_spr = {wb_adr_in == OFS_SPR3, wb_adr_in == OFS_SPR2, wb_adr_in == OFS_SPR1,
    wb_adr_in == OFS_SPR0};
  wire adr_en = wb_adr_in == OFS_ENABLE;
  wire adr_st = wb_adr_in == OFS_STATUS;
  wire adr_vec = wb_adr_in == OFS_VECTOR;
  wire mapped = adr_cond || (|adr_spr) || adr_en || adr_st || adr_vec;
  wire bus_wr = bus_req && mapped && wb_we_in && wlane;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (adr_cond) rd_mux = {24'h000000, cond};
    for (int k = 0; k < 4; k++) if (adr_spr[k]) rd_mux = {24'h000000, spr[k]};
    if (adr_en) rd_mux = {23'h000000, enable};
    if (adr_st) rd_mux = {20'h00000, state, pending};
    if (adr_vec) rd_mux = {16'h0000, entry_out.vector};
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cond <= COND_RESET;
      trap_pend <= 1'b0;
      for (int k = 0; k < 4; k++) spr[k] <= SPR_RESET;
      enable <= ENABLE_RESET;
      pending <= 9'h000;
      state <= ST_RUN;
      entry_valid <= 1'b0;
      entry_out <= '0;
      wb_ack_out <= 1'b0;
      wb_err_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      cond <= (bus_wr && adr_cond) ? wdat : next_cond;
      trap_pend <= (trap_pend || cmd_in.op == OP_TRAP) && !(taking && entry_out.vector == VEC_TRAP);
      for (int k = 0; k < 4; k++) begin
        if (bus_wr && adr_spr[k]) begin
          spr[k] <= (k == 3) ? ((spr[k] & SPR3_RO_MASK) | (wdat & ~SPR3_RO_MASK)) : wdat;
        end
      end
      if (bus_wr && adr_en) enable <= wb_dat_in[8:0];
      // Latch until served; new edge wins over the clearing take
      pending <= (pending & ~((taking && !entry_out.nmi) || (taking && entry_out.src == 4'h0 &&
        entry_out.vector == VEC_SRC0) ? (9'h001 << entry_out.src) : 9'h000)) | irq_rise;
      state <= next_state;
      entry_valid <= entry_req && !taking;
      if (!taking) entry_out <= next_entry;
      wb_ack_out <= bus_req && mapped;
      wb_err_out <= bus_req && !mapped;
      wb_dat_out <= rd_mux;
    end
  end

  assign entry_valid_out = entry_valid;
  assign condition_code_register_out = cond;
  assign cpu_stop_out = (state != ST_RUN);
  assign periph_clk_en_out = (state != ST_HALT);
  assign suspend_wake_out = |(pending & SUSPEND_EXIT_MASK);

  AST_RESET_RUN: assert property (@(posedge clock_in) $rose(rst_n_in) |-> state == ST_RUN)
    else $error("not run after reset");
  AST_WAIT_ENTRY: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    state == ST_RUN && cmd_in.op == OP_WAIT && !taking |=> cpu_stop_out && cond[5] && !cond[3])
    else $error("wait entry wrong");
  AST_WAIT_PERIPH: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    state == ST_WAIT |-> periph_clk_en_out) else $error("peripherals stopped in wait");
  AST_NMI_LVL3: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    taking && entry_out.nmi |=> cur_lvl == LVL3) else $error("nmi level");
  AST_HALT_SRC0: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    state == ST_HALT |-> !(win_any && win == 4'h0)) else $error("src0 left halt");
  AST_LOAD_PRIO: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    taking && !entry_out.nmi && cmd_in.op == OP_NONE |=> cur_lvl == $past(src_prio[entry_out.src]))
    else $error("priority not loaded");
  AST_WAKE_RUN: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    state == ST_WAIT && taking |=> state == ST_RUN) else $error("no wake");
  AST_SPR3_RO: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    1'b1 |=> spr[3][7:4] == 4'hF) else $error("spr3 high bits changed");
  COV_WAIT_WAKE: cover property (@(posedge clock_in) state == ST_WAIT ##[1:20] state == ST_RUN);
  COV_TRAP: cover property (@(posedge clock_in) cmd_in.op == OP_TRAP);
  COV_HALT_EXIT: cover property (@(posedge clock_in) state == ST_HALT && taking);
endmodule
`default_nettype wire

// ### logic/ipw_pkg.sv
/*
  Package for the interrupt priority, vector and wait-mode block:
  register offsets, reset values, encodings and carrier types.
  Assumes a 32-bit classic Wishbone register bus and one 100 MHz clock.
*/
package ipw_pkg;
  localparam int NUM_SRC = 9;
  // Byte offsets of the registers on the bus
  localparam logic [7:0] OFS_COND = 8'h00;
  localparam logic [7:0] OFS_SPR0 = 8'h04;
  localparam logic [7:0] OFS_SPR1 = 8'h08;
  localparam logic [7:0] OFS_SPR2 = 8'h0C;
  localparam logic [7:0] OFS_SPR3 = 8'h10;
  localparam logic [7:0] OFS_ENABLE = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_VECTOR = 8'h1C;
  // Condition-code fields
  localparam int COND_PRIO_HI_POS = 5;
  localparam int COND_PRIO_LO_POS = 3;
  localparam logic [7:0] COND_RESET = 8'hFA;
  localparam logic [7:0] SPR_RESET = 8'hFF;
  localparam logic [7:0] SPR3_RO_MASK = 8'hF0;
  localparam logic [8:0] ENABLE_RESET = 9'h000;
  // Sources that may leave halt: 3,4,7
  localparam logic [8:0] HALT_EXIT_MASK = 9'h098;
  localparam logic [8:0] SUSPEND_EXIT_MASK = 9'h040;
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP = 16'hFFFC;
  localparam logic [15:0] VEC_SRC0 = 16'hFFFA;
  localparam int FLASH_SRC = 0;
  // Priority bit pairs {high,low}
  localparam logic [1:0] LVL0 = 2'h2;
  localparam logic [1:0] LVL1 = 2'h1;
  localparam logic [1:0] LVL2 = 2'h0;
  localparam logic [1:0] LVL3 = 2'h3;
  localparam logic [1:0] WAIT_PRIO = 2'h2;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_UNMASK = 4'h1, OP_MASK = 4'h2, OP_HALT = 4'h3,
    OP_WAIT = 4'h4, OP_RETURN_FROM_IRQ_INSTR = 4'h5, OP_POPFLAGS = 4'h6, OP_TRAP = 4'h7, OP_WRCOND = 4'h8
  } ipw_op_t;

  typedef struct packed {
    ipw_op_t op;
    logic [7:0] data;
  } ipw_cmd_t;

  typedef struct packed {
    logic [15:0] vector;
    logic [3:0] src;
    logic nmi;
  } ipw_entry_t;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001, ST_WAIT = 3'b010, ST_HALT = 3'b100
  } ipw_state_t;
endpackage

// ### bench/ipw_core_model.sv
/*
  Behavioural model of the core sequencer: accepts each presented entry.
  Assumes entry_valid holds until take and falls the cycle after it.
*/
`timescale 1ns/10ps
`default_nettype none
module ipw_core_model (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic entry_valid_in,
  input wire logic [3:0] delay_in,
  output logic take_out
);
  logic [3:0] cnt;
  // Delay 0 answers one cycle after entry_valid, larger values stall the entry
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= 4'h0;
      take_out <= 1'b0;
    end else if (take_out || !entry_valid_in) begin
      cnt <= 4'h0;
      take_out <= 1'b0;
    end else if (cnt >= delay_in) begin
      take_out <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ### bench/tb.sv
/*
  Bench for the priority, vector and wait block: bus, command and entry tasks.
  Assumes the core model answers every entry; one 100 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module tb import ipw_pkg::*;;
  logic clock_in, rst_n_in, cyc, stb, we, bad, take, ack, err, ev, stop, pclk, sw;
  logic [7:0] adr, cond;
  logic [31:0] wdat, dat, rdat;
  logic [8:0] irq;
  logic [3:0] dly;
  ipw_cmd_t cmd;
  ipw_entry_t ent, e;
  int failures = 0;
  int n_compared = 0;
  ipw_ctrl u_dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(dat),
    .wb_ack_out(ack), .wb_err_out(err), .cmd_in(cmd), .irq_req_in(irq), .take_in(take),
    .entry_valid_out(ev), .entry_out(ent), .condition_code_register_out(cond),
    .cpu_stop_out(stop), .periph_clk_en_out(pclk), .suspend_wake_out(sw));
  ipw_core_model u_core (.clock_in(clock_in), .rst_n_in(rst_n_in), .entry_valid_in(ev),
    .delay_in(dly), .take_out(take));
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clock_in);
      #1;
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
    bad = err;
    rdat = dat;
    @(posedge clock_in);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 50) failures++;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), x, rdat);
  endtask
  task automatic op(input ipw_op_t o, input logic [7:0] d);
    @(posedge clock_in);
    cmd <= '{o, d};
    @(posedge clock_in);
    cmd <= '{OP_NONE, 8'h00};
    @(posedge clock_in);
    #1;
  endtask
  // Caller raises the cause at an edge; the pulse is cleared one cycle later
  task automatic await_entry(output ipw_entry_t x);
    int n;
    n = 0;
    @(posedge clock_in);
    cmd <= '{OP_NONE, 8'h00};
    irq <= 9'h000;
    #1;
    while (ev !== 1'b1 && n < 40) begin
      @(posedge clock_in);
      #1;
      n++;
    end
    x = ent;
    while (ev === 1'b1 && n < 80) begin
      @(posedge clock_in);
      #1;
      n++;
    end
    chk("entry_valid", 1'b0, ev);
  endtask
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  initial begin
    #300000;
    failures++;
    tally_and_finish();
  end
  initial begin
    {rst_n_in, cyc, stb, we, adr, wdat, irq} = '0;
    cmd = '{OP_NONE, 8'h00};
    dly = 4'h6;
    repeat (12) @(posedge clock_in);
    rst_n_in <= 1'b1;
    #1;
    chk("cond", 8'hFA, cond);
    chk("run", 2'b01, {stop, pclk});
    chk("swake", 1'b0, sw);
    rd(OFS_COND, 32'hFA);
    for (int i = 0; i < 4; i++) rd(OFS_SPR0 + 8'(4 * i), 32'hFF);
    bus(1'b1, OFS_SPR3, 32'h0);
    rd(OFS_SPR3, 32'hF0);
    bus(1'b0, 8'h20, 32'h0);
    chk("err", 1'b1, bad);
    bus(1'b1, OFS_SPR0, 32'h7F);
    bus(1'b1, OFS_ENABLE, 32'h38);
    @(posedge clock_in);
    irq[3] <= 1'b1;
    repeat (10) @(posedge clock_in);
    #1;
    chk("held", 1'b0, ev);
    op(OP_UNMASK, 8'hE2);
    chk("cond", 8'hE2, cond);
    await_entry(e);
    chk("src3", {16'hFFF4, 4'h3, 1'b0}, e);
    chk("cond", 8'hCA, cond);
    op(OP_WAIT, 8'h00);
    chk("cond", 8'hE2, cond);
    chk("wait", 2'b11, {stop, pclk});
    dly = 4'h0;
    @(posedge clock_in);
    irq <= 9'h030;
    await_entry(e);
    chk("src4", {16'hFFF2, 4'h4, 1'b0}, e);
    chk("cond", 8'hEA, {cond[7:1], stop});
    repeat (10) @(posedge clock_in);
    #1;
    chk("pend5", 1'b0, ev);
    op(OP_RETURN_FROM_IRQ_INSTR, 8'hE2);
    await_entry(e);
    chk("src5", {16'hFFF0, 4'h5, 1'b0}, e);
    @(posedge clock_in);
    irq[0] <= 1'b1;
    await_entry(e);
    chk("src0", {16'hFFFA, 4'h0, 1'b1}, e);
    chk("cond", 8'hEA, cond);
    @(posedge clock_in);
    cmd <= '{OP_TRAP, 8'h00};
    await_entry(e);
    chk("trap", {16'hFFFC, 1'b1}, {e.vector, e.nmi});
    op(OP_HALT, 8'hE2);
    chk("halt", 2'b10, {stop, pclk});
    @(posedge clock_in);
    irq[0] <= 1'b1;
    irq[6] <= 1'b1;
    repeat (10) @(posedge clock_in);
    #1;
    chk("nowake", 1'b0, ev);
    chk("swake", 1'b1, sw);
    @(posedge clock_in);
    irq[3] <= 1'b1;
    await_entry(e);
    chk("wake", {16'hFFF4, 4'h3, 1'b0}, e);
    tally_and_finish();
  end
endmodule
`default_nettype wire
